// [rtl/pcg_pkg.sv]
// Package with register map, field layout, state types and bus carriers for the clock gating block.
package pcg_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFF_SYS_EN = 8'h00;
   localparam logic [7:0] OFF_SYS_DIS = 8'h04;
   localparam logic [7:0] OFF_SYS_STATE = 8'h08;
   localparam logic [7:0] OFF_PER_EN = 8'h10;
   localparam logic [7:0] OFF_PER_DIS = 8'h14;
   localparam logic [7:0] OFF_PER_STATE = 8'h18;
   localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
   localparam logic [7:0] OFF_FREQ_MEAS = 8'h24;
   localparam logic [7:0] OFF_PLL_A = 8'h28;
   localparam logic [7:0] OFF_PLL_B = 8'h2C;
   localparam logic [7:0] OFF_MCK = 8'h30;
   localparam logic [7:0] OFF_PCK0 = 8'h40;
   localparam logic [7:0] OFF_PCK1 = 8'h44;
   localparam logic [7:0] OFF_IRQ_EN = 8'h60;
   localparam logic [7:0] OFF_IRQ_DIS = 8'h64;
   localparam logic [7:0] OFF_STATUS = 8'h68;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h6C;
   localparam logic [7:0] OFF_CP_CURRENT = 8'h80;

   // Field positions.
   localparam int SYS_HOST_BIT = 6;
   localparam int SYS_DEV_BIT = 7;
   localparam int SYS_PCK_LSB = 8;
   localparam int SR_MCK_RDY_BIT = 3;
   localparam int SR_PCK_RDY_LSB = 8;
   localparam int PLL_CNT_LSB = 8;
   localparam int CSS_LSB = 0;
   localparam int PRESCALE_SELECT_LSB = 2;
   localparam int NUM_PCK = 2;

   // Writable masks and reset values.
   localparam logic [31:0] SYS_WR_MASK = 32'h0000_03C0;
   localparam logic [31:0] SYS_STATE_RST = 32'h0000_0003;
   localparam logic [31:0] PER_MASK = 32'h0000_7FFC;
   localparam logic [31:0] PLL_RST = 32'h0000_3F00;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [2:0] PRESCALE_SELECT_MAX = 3'h6;

   // Master clock switch timing, in ticks of the named source.
   localparam logic [7:0] MS_SLOW_TICKS = 8'h04;
   localparam logic [7:0] MS_NEW_TICKS = 8'h02;
   localparam logic [7:0] MS_PRESCALE_SELECT_EXTRA = 8'h40;

   // Clock source index: 0 slow, 1 main, 2 first PLL, 3 second PLL.
   localparam logic [1:0] SRC_SLOW = 2'h0;
   localparam logic [1:0] SRC_PLL_A = 2'h2;

   typedef enum logic [1:0] {MS_IDLE, MS_SLOW, MS_LOCK, MS_NEW} pcg_ms_e;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } pcg_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pcg_axi_rsp_s;

endpackage

// [rtl/pcg_clock_gate.sv]
// Clock gating and switching controller with an AXI4-Lite register bank.
//
// Notes on behaviour
// (RQ1) Two programmable outputs, enabled and disabled separately.
// (RQ2) State register shows each programmable output enable.
// (RQ3) Programmable outputs start disabled after reset.
// (RQ4) Source is main, slow or PLL; slow default.
// (RQ5) Output divides source by 1 to 64.
// (RQ6) Ready flag sets once enabled clock runs.
// (RQ7) Masked ready flag raises the interrupt line.
// (RQ8) Source and prescaler taken in one write.
// (RQ9) Software disables before reconfiguring, then waits ready.
// (RQ10) Thirteen peripheral clocks, set and clear registers.
// (RQ11) Peripheral state register shows enabled clocks.
// (RQ12) Peripheral clock is gated master clock, undivided.
// (RQ13) Active master prescaler adds 64 new-source ticks.
// (RQ14) Slow/main switches finish within bounded ticks.
// (RQ15) Switch to PLL includes its lock count.
// (RQ16) Switch away from PLL finishes bounded.
// (RQ17) Host port bit one enables host clocks.
// (RQ18) Device port bit one enables device clock.
// (RQ19) Bits 8 and 9 enable programmable outputs.
// (RQ20) Disable register ones turn outputs off.
// (RQ21) Reserved offsets ignore writes, read zero.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pcg_clock_gate
   import pcg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire pcg_axi_req_s axi_req,
   output pcg_axi_rsp_s axi_rsp,
   input wire logic [3:0] src_tick,
   output logic [NUM_PCK-1:0] prog_clk_tick,
   output logic master_clk_tick,
   output logic [31:0] periph_clk_tick,
   output logic host_port_clk_en,
   output logic device_port_clk_en,
   output logic irq
);

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [31:0] sys_state;
      logic [31:0] per_state;
      logic [31:0] osc_ctrl;
      logic [31:0] pll_a;
      logic [31:0] pll_b;
      logic [31:0] mck_cfg;
      logic [31:0] pck0_cfg;
      logic [31:0] pck1_cfg;
      logic [31:0] irq_mask;
      logic [31:0] cp_current;
      logic [NUM_PCK-1:0] pck_rdy;
      logic [6:0] pck0_cnt;
      logic [6:0] pck1_cnt;
      logic [NUM_PCK-1:0] pck_tick;
      pcg_ms_e ms_state;
      logic [7:0] ms_cnt;
      logic [1:0] mck_css;
      logic [2:0] mck_prescale_select;
      logic [6:0] mck_cnt;
      logic mck_rdy;
      logic mck_tick;
      logic [31:0] per_tick;
      logic irq;
   } pcg_state_s;

   pcg_state_s st_q;
   pcg_state_s st_d;
   logic [31:0] wmask;
   logic do_write;
   logic [31:0] status;
   logic [31:0] rd_mux;

   // Clamp a prescale field and return its terminal count.
   function automatic logic [6:0] prescale_select_last(input logic [2:0] prescale_select);
      logic [2:0] p;
      p = (prescale_select > PRESCALE_SELECT_MAX) ? PRESCALE_SELECT_MAX : prescale_select;
      prescale_select_last = 7'((8'h01 << p) - 8'h01);
   endfunction

   // Byte enables widen to a bit mask so partial writes only touch their lanes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{st_q.w_strb[i]}};
      end
   end

   assign do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;

   // Status view: master ready and per-output ready flags.
   always_comb begin
      status = 32'h0000_0000;
      status[SR_MCK_RDY_BIT] = st_q.mck_rdy;
      status[SR_PCK_RDY_LSB +: NUM_PCK] = st_q.pck_rdy; // see (RQ6)
   end

   // Read decode; anything unlisted answers zero.
   always_comb begin
      case (axi_req.araddr[7:0])
         OFF_SYS_STATE: rd_mux = st_q.sys_state; // see (RQ2)
         OFF_PER_STATE: rd_mux = st_q.per_state; // see (RQ11)
         OFF_OSC_CTRL: rd_mux = st_q.osc_ctrl;
         OFF_PLL_A: rd_mux = st_q.pll_a;
         OFF_PLL_B: rd_mux = st_q.pll_b;
         OFF_MCK: rd_mux = st_q.mck_cfg;
         OFF_PCK0: rd_mux = st_q.pck0_cfg;
         OFF_PCK1: rd_mux = st_q.pck1_cfg;
         OFF_STATUS: rd_mux = status;
         OFF_IRQ_MASK: rd_mux = st_q.irq_mask;
         default: rd_mux = 32'h0000_0000; // see (RQ21)
      endcase
      if (axi_req.araddr[31:8] != 24'h00_0000) begin
         rd_mux = 32'h0000_0000;
      end
   end

   // Next-state logic for the whole block.
   always_comb begin
      logic [31:0] wd;
      logic [1:0] source_select;
      logic [6:0] last;
      logic [7:0] goal;
      wd = st_q.w_data & wmask;
      source_select = 2'h0;
      last = 7'h00;
      goal = 8'h00;
      st_d = st_q;
      st_d.pck_tick = '0;
      st_d.mck_tick = 1'b0;

      // Write channel: address and data may arrive in either order.
      if (axi_req.awvalid && !st_q.aw_held) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = (axi_req.awaddr[31:8] != 24'h00_0000) ? 8'hFC : axi_req.awaddr[7:0];
      end
      if (axi_req.wvalid && !st_q.w_held) begin
         st_d.w_held = 1'b1;
         st_d.w_data = axi_req.wdata;
         st_d.w_strb = axi_req.wstrb;
      end
      if (st_q.bvalid && axi_req.bready) begin
         st_d.bvalid = 1'b0;
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
      end

      // Read channel: one read at a time, answered next cycle.
      if (axi_req.arvalid && !st_q.rvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd_mux;
      end else if (st_q.rvalid && axi_req.rready) begin
         st_d.rvalid = 1'b0;
      end

      // Register writes; set and clear registers act only on ones.
      if (do_write) begin
         st_d.bvalid = 1'b1;
         case (st_q.aw_addr)
            OFF_SYS_EN: st_d.sys_state = st_q.sys_state | (wd & SYS_WR_MASK); // see (RQ1) (RQ17) (RQ18) (RQ19)
            OFF_SYS_DIS: st_d.sys_state = st_q.sys_state & ~(wd & SYS_WR_MASK); // see (RQ20)
            OFF_PER_EN: st_d.per_state = st_q.per_state | (wd & PER_MASK); // see (RQ10)
            OFF_PER_DIS: st_d.per_state = st_q.per_state & ~(wd & PER_MASK); // see (RQ10)
            OFF_OSC_CTRL: st_d.osc_ctrl = (st_q.osc_ctrl & ~wmask) | wd;
            OFF_PLL_A: st_d.pll_a = (st_q.pll_a & ~wmask) | wd;
            OFF_PLL_B: st_d.pll_b = (st_q.pll_b & ~wmask) | wd;
            OFF_MCK: begin
               st_d.mck_cfg = (st_q.mck_cfg & ~wmask) | wd;
               st_d.mck_rdy = 1'b0;
               st_d.ms_state = MS_SLOW;
               st_d.ms_cnt = 8'h00;
            end
            OFF_PCK0: begin
               st_d.pck0_cfg = (st_q.pck0_cfg & ~wmask) | wd; // see (RQ8)
               st_d.pck0_cnt = 7'h00;
            end
            OFF_PCK1: begin
               st_d.pck1_cfg = (st_q.pck1_cfg & ~wmask) | wd; // see (RQ8)
               st_d.pck1_cnt = 7'h00;
            end
            OFF_IRQ_EN: st_d.irq_mask = st_q.irq_mask | wd;
            OFF_IRQ_DIS: st_d.irq_mask = st_q.irq_mask & ~wd;
            OFF_CP_CURRENT: st_d.cp_current = (st_q.cp_current & ~wmask) | wd;
            default: st_d.bvalid = 1'b1; // see (RQ21)
         endcase
      end

      // Programmable output 0: source pick, power-of-two prescaler, ready on first output tick.
      source_select = st_q.pck0_cfg[CSS_LSB +: 2]; // see (RQ4)
      last = prescale_select_last(st_q.pck0_cfg[PRESCALE_SELECT_LSB +: 3]);
      if (st_q.sys_state[SYS_PCK_LSB] && src_tick[source_select]) begin
         if (st_q.pck0_cnt >= last) begin
            st_d.pck0_cnt = 7'h00;
            st_d.pck_tick[0] = 1'b1; // see (RQ5)
         end else begin
            st_d.pck0_cnt = 7'(st_q.pck0_cnt + 7'h01);
         end
      end
      // Programmable output 1, same structure.
      source_select = st_q.pck1_cfg[CSS_LSB +: 2]; // see (RQ4)
      last = prescale_select_last(st_q.pck1_cfg[PRESCALE_SELECT_LSB +: 3]);
      if (st_q.sys_state[SYS_PCK_LSB + 1] && src_tick[source_select]) begin
         if (st_q.pck1_cnt >= last) begin
            st_d.pck1_cnt = 7'h00;
            st_d.pck_tick[1] = 1'b1; // see (RQ5)
         end else begin
            st_d.pck1_cnt = 7'(st_q.pck1_cnt + 7'h01);
         end
      end

      // Ready follows the running output; a disable or reconfigure drops it.
      for (int i = 0; i < NUM_PCK; i++) begin
         if (!st_d.sys_state[SYS_PCK_LSB + i]) begin
            st_d.pck_rdy[i] = 1'b0;
            st_d.pck_tick[i] = 1'b0;
         end else if (st_d.pck_tick[i]) begin
            st_d.pck_rdy[i] = 1'b1; // see (RQ6)
         end
      end
      if (do_write && st_q.aw_addr == OFF_PCK0) begin
         st_d.pck_rdy[0] = 1'b0; // see (RQ9)
      end
      if (do_write && st_q.aw_addr == OFF_PCK1) begin
         st_d.pck_rdy[1] = 1'b0; // see (RQ9)
      end

      // Master clock switch: slow ticks, optional PLL lock wait, then new-source ticks.
      source_select = st_q.mck_cfg[CSS_LSB +: 2];
      goal = MS_NEW_TICKS + ((st_q.mck_cfg[PRESCALE_SELECT_LSB +: 3] != 3'h0) ? MS_PRESCALE_SELECT_EXTRA : 8'h00); // see (RQ13)
      case (st_q.ms_state)
         MS_IDLE: st_d.ms_cnt = 8'h00;
         MS_SLOW: begin
            if (src_tick[SRC_SLOW]) begin
               st_d.ms_cnt = 8'(st_q.ms_cnt + 8'h01);
            end
            if (st_q.ms_cnt >= MS_SLOW_TICKS) begin // see (RQ14) (RQ16)
               st_d.ms_cnt = 8'h00;
               st_d.ms_state = source_select[1] ? MS_LOCK : MS_NEW;
            end
         end
         MS_LOCK: begin
            if (src_tick[SRC_SLOW]) begin
               st_d.ms_cnt = 8'(st_q.ms_cnt + 8'h01);
            end
            if (st_q.ms_cnt >= {2'b00, (source_select == SRC_PLL_A) ? st_q.pll_a[PLL_CNT_LSB +: 6]
                                                         : st_q.pll_b[PLL_CNT_LSB +: 6]}) begin // see (RQ15)
               st_d.ms_cnt = 8'h00;
               st_d.ms_state = MS_NEW;
            end
         end
         MS_NEW: begin
            if (src_tick[source_select]) begin
               st_d.ms_cnt = 8'(st_q.ms_cnt + 8'h01);
            end
            if (st_q.ms_cnt >= goal) begin
               st_d.ms_state = MS_IDLE;
               st_d.mck_css = source_select;
               st_d.mck_prescale_select = st_q.mck_cfg[PRESCALE_SELECT_LSB +: 3];
               st_d.mck_cnt = 7'h00;
               st_d.mck_rdy = 1'b1;
            end
         end
         default: st_d.ms_state = MS_IDLE;
      endcase
      // A new write restarts the switch even mid-sequence.
      if (do_write && st_q.aw_addr == OFF_MCK) begin
         st_d.ms_state = MS_SLOW;
         st_d.ms_cnt = 8'h00;
         st_d.mck_rdy = 1'b0;
      end

      // Master tick keeps the old source until the switch completes, so it never glitches.
      last = prescale_select_last(st_q.mck_prescale_select);
      if (src_tick[st_q.mck_css]) begin
         if (st_q.mck_cnt >= last) begin
            st_d.mck_cnt = 7'h00;
            st_d.mck_tick = 1'b1;
         end else begin
            st_d.mck_cnt = 7'(st_q.mck_cnt + 7'h01);
         end
      end

      // Peripheral clocks are the master tick, gated by their enable bit.
      st_d.per_tick = {32{st_d.mck_tick}} & st_d.per_state; // see (RQ12)

      // Interrupt line is a level from masked status.
      st_d.irq = |({st_d.pck_rdy, 4'h0, st_d.mck_rdy, 3'h0} & st_d.irq_mask[SR_PCK_RDY_LSB + 1:0]); // see (RQ7)
   end

   // One register stage for the whole state, synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.sys_state <= SYS_STATE_RST; // see (RQ3)
         st_q.pll_a <= PLL_RST;
         st_q.pll_b <= PLL_RST;
         st_q.mck_cfg <= CFG_RST;
         st_q.pck0_cfg <= CFG_RST; // see (RQ4) (RQ5)
         st_q.pck1_cfg <= CFG_RST;
         st_q.ms_state <= MS_IDLE;
         st_q.mck_rdy <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs.
   assign axi_rsp.awready = !st_q.aw_held;
   assign axi_rsp.wready = !st_q.w_held;
   assign axi_rsp.bvalid = st_q.bvalid;
   assign axi_rsp.bresp = 2'h0;
   assign axi_rsp.arready = !st_q.rvalid;
   assign axi_rsp.rvalid = st_q.rvalid;
   assign axi_rsp.rdata = st_q.rdata;
   assign axi_rsp.rresp = 2'h0;
   assign prog_clk_tick = st_q.pck_tick;
   assign master_clk_tick = st_q.mck_tick;
   assign periph_clk_tick = st_q.per_tick;
   assign host_port_clk_en = st_q.sys_state[SYS_HOST_BIT];
   assign device_port_clk_en = st_q.sys_state[SYS_DEV_BIT];
   assign irq = st_q.irq;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic wr_dis_q;
   logic [31:0] wr_data_q;
   logic [31:0] wd_view;
   assign wd_view = st_q.w_data & wmask;
   always_ff @(posedge aclk) begin
      wr_dis_q <= do_write && st_q.aw_addr == OFF_SYS_DIS;
      wr_data_q <= wd_view;
   end

   sequence s_sys_en_write;
      do_write && st_q.aw_addr == OFF_SYS_EN;
   endsequence
   sequence s_mck_write;
      do_write && st_q.aw_addr == OFF_MCK;
   endsequence

   property p_reset_disabled;
      @(posedge aclk) disable iff (1'b0) !aresetn |=> st_q.sys_state[SYS_PCK_LSB +: NUM_PCK] == 2'b00;
   endproperty
   a_reset_disabled: assert property (p_reset_disabled) else $error("Programmable output enabled after reset."); // see (RQ3)

   property p_enable_sets;
      s_sys_en_write |=> (st_q.sys_state & (wr_data_q & SYS_WR_MASK)) == (wr_data_q & SYS_WR_MASK);
   endproperty
   a_enable_sets: assert property (p_enable_sets) else $error("Enable write did not set its bits."); // see (RQ19)

   property p_disable_clears;
      wr_dis_q |-> (st_q.sys_state & wr_data_q & SYS_WR_MASK) == 32'h0000_0000;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("Disable write left bits set."); // see (RQ20)

   property p_ready_needs_enable;
      st_q.pck_rdy[0] |-> st_q.sys_state[SYS_PCK_LSB];
   endproperty
   a_ready_needs_enable: assert property (p_ready_needs_enable) else $error("Ready flag set on a disabled output."); // see (RQ6)

   property p_irq_on_ready;
      $rose(st_q.pck_rdy[1]) && st_q.irq_mask[SR_PCK_RDY_LSB + 1] |-> irq;
   endproperty
   a_irq_on_ready: assert property (p_irq_on_ready) else $error("Masked-in ready flag did not raise the line."); // see (RQ7)

   property p_periph_gate;
      periph_clk_tick != 32'h0000_0000 |-> master_clk_tick && (periph_clk_tick & ~st_q.per_state) == 32'h0000_0000;
   endproperty
   a_periph_gate: assert property (p_periph_gate) else $error("Peripheral tick outside its gate."); // see (RQ12)

   property p_div_one;
      st_q.sys_state[SYS_PCK_LSB] && st_q.pck0_cfg[PRESCALE_SELECT_LSB +: 3] == 3'h0 && src_tick[st_q.pck0_cfg[1:0]]
         && !do_write |=> prog_clk_tick[0];
   endproperty
   a_div_one: assert property (p_div_one) else $error("Undivided output missed a source tick."); // see (RQ5)

   property p_mck_switch;
      s_mck_write |=> !st_q.mck_rdy ##1 st_q.ms_state != MS_IDLE || st_q.mck_rdy;
   endproperty
   a_mck_switch: assert property (p_mck_switch) else $error("Master ready not dropped on switch."); // see (RQ14)

   property p_host_port;
      s_sys_en_write ##0 wd_view[SYS_HOST_BIT] |=> host_port_clk_en;
   endproperty
   a_host_port: assert property (p_host_port) else $error("Host port clock not enabled."); // see (RQ17)

   property p_unmapped_read;
      axi_req.arvalid && !st_q.rvalid && axi_req.araddr[7:0] == 8'h0C |=> axi_rsp.rvalid && axi_rsp.rdata == 32'h0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("Reserved offset read not zero."); // see (RQ21)

endmodule

// [verif/pcg_clock_gate_test.sv]
// Self-checking testbench for the clock gating controller with a reference model.
`timescale 1ns/1ps
module pcg_clock_gate_test
   import pcg_pkg::*;
();
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   pcg_axi_req_s req;
   pcg_axi_rsp_s rsp;
   logic [3:0] src_tick = 4'h0;
   logic [NUM_PCK-1:0] prog_tick;
   logic mst_tick;
   logic [31:0] per_tick;
   logic host_en;
   logic dev_en;
   logic irq;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   logic cnt_on = 1'b0;
   int src_cnt[4];
   int prog_cnt;
   int prog1_cnt;
   int mst_cnt;
   int per_cnt;
   logic [31:0] rng = 32'h0000_F7F7;
   logic [31:0] sys_m = 32'h0000_0003;
   logic [31:0] per_m = 32'h0000_0000;
   int per_cyc[4] = '{8, 2, 1, 3};

   pcg_clock_gate dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .src_tick(src_tick),
      .prog_clk_tick(prog_tick), .master_clk_tick(mst_tick), .periph_clk_tick(per_tick),
      .host_port_clk_en(host_en), .device_port_clk_en(dev_en), .irq(irq));

   // The clock toggles every half period of 12.5 ns.
   always #12.5 aclk = ~aclk;

   // Sources tick at unequal rates, so a wrong source choice shows up in the output rate.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      src_tick <= {(cyc % 3) == 0, 1'b1, (cyc % 2) == 0, (cyc % 8) == 0};
      for (int i = 0; i < 4; i++) src_cnt[i] <= cnt_on ? src_cnt[i] + int'(src_tick[i]) : 0;
      prog_cnt <= cnt_on ? prog_cnt + int'(prog_tick[0]) : 0;
      prog1_cnt <= cnt_on ? prog1_cnt + int'(prog_tick[1]) : 0;
      mst_cnt <= cnt_on ? mst_cnt + int'(mst_tick) : 0;
      per_cnt <= cnt_on ? per_cnt + int'(per_tick[2]) : 0;
   end

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_int(input int got, input int lo, input int hi, input string what);
      n_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("mismatch at %0t: %s got %0d expected %0d to %0d", $time, what, got, lo, hi);
      end
   endtask

   // Each channel is held until its own ready edge; bready stays up until bvalid is seen.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      check({30'h0, rsp.bresp}, 32'h0, "write response");
      req.bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      d = rsp.rdata;
      check({30'h0, rsp.rresp}, 32'h0, "read response");
      req.rready <= 1'b0;
   endtask

   task automatic rd_check(input logic [31:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      axi_read(a, v);
      check(v, exp, what);
   endtask

   // Writes go through the model too, so the system and peripheral set and clear registers are tracked bit by bit.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_write({24'h00_0000, a}, d);
      case (a)
         OFF_SYS_EN: sys_m = sys_m | (d & SYS_WR_MASK);
         OFF_SYS_DIS: sys_m = sys_m & ~(d & SYS_WR_MASK);
         OFF_PER_EN: per_m = per_m | (d & PER_MASK);
         OFF_PER_DIS: per_m = per_m & ~(d & PER_MASK);
         default: ;
      endcase
   endtask

   // Polling is bounded by a read count; the elapsed time is then held against the limit.
   task automatic wait_flag(input logic [31:0] m, input int limit, input string what);
      logic [31:0] v;
      time t0;
      t0 = $time;
      v = '0;
      for (int n = 0; n < 400 && (v & m) === 32'h0; n++) axi_read({24'h00_0000, OFF_STATUS}, v);
      check(v & m, m, what);
      chk_int(int'(($time - t0) / 25), 0, limit, what);
   endtask

   task automatic count_for(input int n);
      cnt_on <= 1'b1;
      repeat (n) @(posedge aclk);
      cnt_on <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the expected run length.
   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      complete_run();
   end

   initial begin
      logic [31:0] v;
      logic [31:0] cfg;
      req = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd_check(OFF_SYS_STATE, SYS_STATE_RST, "system state reset");
      rd_check(OFF_PER_STATE, 32'h0, "peripheral state reset");
      rd_check(OFF_STATUS, 32'h0000_0008, "status reset");
      rd_check(OFF_PLL_A, PLL_RST, "pll reset");
      rd_check(OFF_PCK0, CFG_RST, "config reset");
      rd_check(OFF_IRQ_MASK, 32'h0, "mask reset");
      $display("test reset done");
      wr(OFF_SYS_EN, 32'h0000_00C0);
      wr(OFF_SYS_EN, 32'h0);
      rd_check(OFF_SYS_STATE, sys_m, "system state after enable");
      check({30'h0, dev_en, host_en}, 32'h3, "port clock enables");
      wr(OFF_SYS_DIS, 32'h0000_0040);
      check({30'h0, dev_en, host_en}, 32'h2, "host clock off");
      wr(OFF_SYS_STATE, 32'hFFFF_FFFF);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd_check(OFF_SYS_STATE, sys_m, "read-only write ignored");
      rd_check(32'h0000_000C, 32'h0, "reserved reads zero");
      $display("test system clocks done");
      for (int i = 0; i < 6; i++) begin
         wr(OFF_PER_EN, xs());
         wr(OFF_PER_DIS, xs() & xs());
         rd_check(OFF_PER_STATE, per_m, "peripheral state");
      end
      $display("test peripherals done");
      // Every source, with prescales 1, 4, 16 and 64.
      for (int s = 0; s < 4; s++) begin
         wr(OFF_SYS_DIS, 32'h0000_0100);
         axi_read({24'h00_0000, OFF_STATUS}, v);
         check(v & 32'h0000_0100, 32'h0, "ready cleared by disable");
         cfg = 32'(s) | (32'(2 * s) << PRESCALE_SELECT_LSB);
         wr(OFF_PCK0, cfg);
         rd_check(OFF_PCK0, cfg, "config readback");
         wr(OFF_SYS_EN, 32'h0000_0100);
         wait_flag(32'h0000_0100, (1 << (2 * s)) * per_cyc[s] + 24, "output ready");
         count_for(640);
         chk_int(prog_cnt, (src_cnt[s] >> (2 * s)) - 1, (src_cnt[s] >> (2 * s)) + 1, "output rate");
      end
      rd_check(OFF_SYS_STATE, sys_m, "system state with output on");
      wr(OFF_IRQ_EN, 32'h0000_0100);
      rd_check(OFF_IRQ_MASK, 32'h0000_0100, "mask set");
      repeat (3) @(posedge aclk);
      check({31'h0, irq}, 32'h1, "irq raised");
      wr(OFF_IRQ_DIS, 32'h0000_0100);
      repeat (3) @(posedge aclk);
      check({31'h0, irq}, 32'h0, "irq masked");
      wr(OFF_SYS_DIS, 32'h0000_0100);
      count_for(200);
      chk_int(prog_cnt, 0, 0, "output stopped");
      // Second output on the main clock divided by 2, its ready flag routed to the line.
      wr(OFF_IRQ_EN, 32'h0000_0200);
      wr(OFF_PCK1, 32'h0000_0005);
      wr(OFF_SYS_EN, 32'h0000_0200);
      wait_flag(32'h0000_0200, 2 * 2 + 24, "second output ready");
      check({31'h0, irq}, 32'h1, "irq from second output");
      count_for(400);
      chk_int(prog1_cnt, (src_cnt[1] >> 1) - 1, (src_cnt[1] >> 1) + 1, "second output rate");
      wr(OFF_SYS_DIS, 32'h0000_0200);
      rd_check(OFF_SYS_STATE, sys_m, "second output off");
      wr(OFF_IRQ_DIS, 32'h0000_0200);
      $display("test programmable clocks done");
      // Master switches: slow to main, prescale on, to the first PLL, back to slow.
      wr(OFF_MCK, 32'h0000_0001);
      wait_flag(32'h0000_0008, 4 * 8 + 3 * 2 + 24, "slow to main");
      wr(OFF_MCK, 32'h0000_0005);
      axi_read({24'h00_0000, OFF_STATUS}, v);
      check(v & 32'h0000_0008, 32'h0, "master ready dropped");
      wait_flag(32'h0000_0008, 4 * 8 + 67 * 2 + 24, "prescaled switch");
      wr(OFF_PER_EN, 32'h0000_0004);
      count_for(400);
      chk_int(per_cnt, mst_cnt, mst_cnt, "peripheral equals master");
      chk_int(mst_cnt, (src_cnt[1] >> 1) - 1, (src_cnt[1] >> 1) + 1, "master rate");
      wr(OFF_MCK, 32'h0000_0006);
      wait_flag(32'h0000_0008, 67 * 8 + 67 + 24, "switch to pll");
      wr(OFF_MCK, 32'h0000_0000);
      wait_flag(32'h0000_0008, 5 * 8 + 3 * 8 + 24, "pll to slow");
      $display("test master switching done");
      complete_run();
   end
endmodule
